// ### verilog/acb_pkg.sv
/*
 * Constants for the per-axis comparator bank: register offsets, field
 * positions, method and action codes, reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acb_pkg;
    localparam logic [7:0]  OFF_SETUP_A  = 8'h00;
    localparam logic [7:0]  OFF_SETUP_B  = 8'h04;
    localparam logic [7:0]  OFF_IRQ_EN   = 8'h08;
    localparam logic [7:0]  OFF_CAUSE    = 8'h0c;
    localparam logic [7:0]  OFF_STATUS   = 8'h10;
    localparam logic [7:0]  OFF_CMP_BASE = 8'h14;
    localparam logic [7:0]  OFF_PRE_MOVE = 8'h28;
    localparam logic [7:0]  OFF_ACT_MOVE = 8'h2c;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

    localparam int NUM_CMP = 5;
    localparam int SRC_LSB [5] = '{0, 8, 16, 24, 0};
    localparam int MTH_LSB [5] = '{2, 10, 18, 26, 3};
    localparam int ACT_LSB [5] = '{5, 13, 21, 30, 6};
    localparam int RING1_BIT = 7;
    localparam int RING2_BIT = 15;
    localparam int EVT_LSB   = 8;
    localparam int DEFL_MAX  = 32767;

    localparam logic [3:0] M_EQ     = 4'h1;
    localparam logic [3:0] M_EQ_UP  = 4'h2;
    localparam logic [3:0] M_EQ_DN  = 4'h3;
    localparam logic [3:0] M_GT     = 4'h4;
    localparam logic [3:0] M_LT     = 4'h5;
    localparam logic [3:0] M_SL     = 4'h6;
    localparam logic [3:0] M_IDX    = 4'h8;
    localparam logic [3:0] M_IDX_UP = 4'h9;
    localparam logic [3:0] M_IDX_DN = 4'ha;

    localparam logic [2:0] SRC_POS   = 3'h4;
    localparam logic [2:0] SRC_SPEED = 3'h5;

    typedef enum logic [1:0] {
        ACT_NONE  = 2'b00,
        ACT_STOP  = 2'b01,
        ACT_DECEL = 2'b10,
        ACT_LOAD  = 2'b11
    } acb_action_t;
endpackage : acb_pkg

// ### verilog/acb_cmp_if.sv
/*
 * Bundle between the bank and one comparator unit.
 * Assumes the bank drives method, values and direction, the unit answers.
 */
`timescale 1ns/100ps
interface acb_cmp_if #(parameter int W = 28);
    logic [3:0]          method;
    logic signed [W-1:0] cmp_val;
    logic signed [W-1:0] cnt_val;
    logic                step;
    logic                up;
    logic                match;
    logic                index_hit;
    modport ctrl (output method, cmp_val, cnt_val, step, up, input match, index_hit);
    modport unit (input method, cmp_val, cnt_val, step, up, output match, index_hit);
endinterface : acb_cmp_if

// ### verilog/acb_cmp_unit.sv
/*
 * One comparator: evaluates the selected method against the counter.
 * Assumes method codes arrive zero-extended to four bits.
 */
`timescale 1ns/100ps
module acb_cmp_unit #(
    parameter int NUM = 0,
    parameter int W   = 28
) (
    input wire logic   clk,
    input wire logic   rst_n,
    acb_cmp_if.unit    c
);
    logic eq;
    logic cond;
    logic idx;

    always_comb begin
        eq   = (c.cnt_val == c.cmp_val);
        cond = 1'b0;
        idx  = 1'b0;
        unique case (c.method)
            acb_pkg::M_EQ:    cond = eq;
            acb_pkg::M_EQ_UP: cond = eq && c.up;
            acb_pkg::M_EQ_DN: cond = eq && !c.up;
            acb_pkg::M_GT:    cond = c.cmp_val > c.cnt_val;
            acb_pkg::M_LT:    cond = c.cmp_val < c.cnt_val;
            acb_pkg::M_SL: begin
                if (NUM == 0) cond = c.cmp_val < c.cnt_val;
                else if (NUM == 1) cond = c.cmp_val > c.cnt_val;
            end
            acb_pkg::M_IDX, acb_pkg::M_IDX_UP, acb_pkg::M_IDX_DN: begin
                if (NUM == 3) begin
                    cond = eq && (c.method == acb_pkg::M_IDX ||
                                  (c.method == acb_pkg::M_IDX_UP) == c.up);
                    idx  = cond && c.step;
                end
            end
            default: cond = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c.match     <= 1'b0;
            c.index_hit <= 1'b0;
        end else begin
            c.match     <= cond;
            c.index_hit <= idx;
        end
    end

    eq_dir_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (c.method == acb_pkg::M_EQ_DN) ##1 c.match |->
            $past(c.cnt_val == c.cmp_val && !c.up))
        else $error("Down-only equality matched on wrong direction");

    mag_cmp_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (c.method == acb_pkg::M_GT) |=> (c.match == $past(c.cmp_val > c.cnt_val)))
        else $error("Greater-than match does not follow the compare");

    sl_cmp3_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (NUM > 1 && c.method == acb_pkg::M_SL) |=> !c.match)
        else $error("Software-limit code matched on a comparator without it");
endmodule : acb_cmp_unit

// ### verilog/acb_bank.sv
/*
 * Per-axis bank of five comparators with register port, actions,
 * event causes, index pulse and ring counter control.
 * Assumes counters live outside and report step and direction per cycle.
 */
// Our own choices: the plain strobed port and the register addresses.
// Overview of operation
// - Codes 001/010/011: equality any, up, down
// - Code 100 compare above counter, 101 below
// - Comparator 4 four-bit method at bits 26-29
// - Code 110 software limit, comparators 1, 2 only
// - Comparator 4 codes 1000-1010 make index pulse
// - Comparator 1 ring bit makes command counter ring
// - Comparator 2 ring bit makes mechanical counter ring
// - Three-bit method fields at their fixed bits
// - Action: none, stop, decelerate, load pre-register
// - Load also copies pre move amount to active
// - Two-bit action fields at their fixed bits
// - Enabled comparator match drives interrupt low
// - Cause bits 8-12 show which comparator fired
// - Status bits 8-12 show live match
// - Five comparators of 28 bits each
// - Source select picks counter, position or speed
// - Deflection source uses absolute value, max 32767
`timescale 1ns/100ps
module acb_bank #(
    parameter int W  = 28,
    parameter int DW = 16
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    input  wire logic signed [W-1:0]  command_position_counter,
    input  wire logic signed [W-1:0]  mechanical_position_counter,
    input  wire logic signed [DW-1:0] deflection_counter,
    input  wire logic signed [W-1:0]  general_purpose_counter,
    input  wire logic signed [W-1:0]  positioning_counter,
    input  wire logic        [W-1:0]  current_speed,
    input  wire logic [3:0]           cnt_step,
    input  wire logic [3:0]           cnt_up,
    output logic                      irq_n,
    output logic [4:0]                cmp_match,
    output logic                      stop_now,
    output logic                      stop_decel,
    output logic                      preload_load,
    output logic [W-1:0]              active_move_amount,
    output logic                      index_sync_pulse,
    output logic                      plus_soft_limit,
    output logic                      minus_soft_limit,
    output logic                      cmd_ring_load,
    output logic [W-1:0]              cmd_ring_value,
    output logic                      mech_ring_load,
    output logic [W-1:0]              mech_ring_value
);
    logic [31:0]         comparator_setup_a_r;
    logic [31:0]         comparator_setup_b_r;
    logic [31:0]         event_interrupt_enable_r;
    logic [4:0]          cause_r;
    logic [4:0]          match_d_r;
    logic [W-1:0]        pre_move_amount_r;
    logic [W-1:0]        cmp_val_r [5];
    logic [3:0]          last_up_r;
    logic [4:0]          match;
    logic [4:0]          index_hit;
    logic [4:0]          rise;
    logic [4:0]          fire_en;
    logic [1:0]          act [5];
    logic [3:0]          mth [5];
    logic [W-1:0]        defl_abs;
    logic [DW-1:0]       defl_mag;
    logic                ring1_en;
    logic                ring2_en;
    logic [31:0]         rdata_nxt;
    logic                any_stop;
    logic                any_decel;
    logic                any_load;

    // Deflection magnitude, clipped to the positive range
    always_comb begin
        defl_mag = deflection_counter[DW-1] ? DW'(-deflection_counter) : deflection_counter;
        defl_abs = W'(defl_mag);
        if (deflection_counter == {1'b1, {(DW-1){1'b0}}}) defl_abs = W'(acb_pkg::DEFL_MAX);
    end

    // Last count direction per counter
    always_ff @(posedge clk) begin
        if (!rst_n) last_up_r <= 4'h0;
        else last_up_r <= (cnt_step & cnt_up) | (~cnt_step & last_up_r);
    end

    genvar i;
    generate
        for (i = 0; i < acb_pkg::NUM_CMP; i++) begin : g_cmp
            acb_cmp_if #(.W(W)) cif ();
            logic [2:0]          src;
            logic signed [W-1:0] sel;
            logic [31:0]         setup;

            assign setup = (i == 4) ? comparator_setup_b_r : comparator_setup_a_r;
            assign mth[i] = (i == 3) ? setup[acb_pkg::MTH_LSB[i] +: 4]
                                     : {1'b0, setup[acb_pkg::MTH_LSB[i] +: 3]};
            assign act[i] = setup[acb_pkg::ACT_LSB[i] +: 2];
            assign src = (i == 4) ? setup[acb_pkg::SRC_LSB[i] +: 3]
                                  : {1'b0, setup[acb_pkg::SRC_LSB[i] +: 2]};

            always_comb begin
                unique case (src)
                    3'h0: sel = command_position_counter;
                    3'h1: sel = mechanical_position_counter;
                    3'h2: sel = defl_abs;
                    3'h3: sel = general_purpose_counter;
                    acb_pkg::SRC_POS: sel = positioning_counter;
                    acb_pkg::SRC_SPEED: sel = current_speed;
                    default: sel = '0;
                endcase
            end

            assign cif.method  = mth[i];
            assign cif.cmp_val = cmp_val_r[i];
            assign cif.cnt_val = sel;
            assign cif.step    = (src < acb_pkg::SRC_POS) ? cnt_step[src[1:0]] : 1'b0;
            // Direction of a step taken this cycle counts at once
            assign cif.up      = (src >= acb_pkg::SRC_POS) ? 1'b1 :
                                 (cnt_step[src[1:0]] ? cnt_up[src[1:0]] : last_up_r[src[1:0]]);
            assign match[i]     = cif.match;
            assign index_hit[i] = cif.index_hit;

            acb_cmp_unit #(.NUM(i), .W(W)) u_cmp (
                .clk   (clk),
                .rst_n (rst_n),
                .c     (cif.unit)
            );
        end
    endgenerate

    assign rise    = match & ~match_d_r;
    assign fire_en = rise & event_interrupt_enable_r[acb_pkg::EVT_LSB +: 5];

    always_comb begin
        any_stop  = 1'b0;
        any_decel = 1'b0;
        any_load  = 1'b0;
        for (int k = 0; k < acb_pkg::NUM_CMP; k++) begin
            if (rise[k]) begin
                unique case (acb_pkg::acb_action_t'(act[k]))
                    acb_pkg::ACT_NONE:  ;
                    acb_pkg::ACT_STOP:  any_stop  = 1'b1;
                    acb_pkg::ACT_DECEL: any_decel = 1'b1;
                    acb_pkg::ACT_LOAD:  any_load  = 1'b1;
                endcase
            end
        end
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comparator_setup_a_r     <= acb_pkg::RST_WORD;
            comparator_setup_b_r     <= acb_pkg::RST_WORD;
            event_interrupt_enable_r <= acb_pkg::RST_WORD;
            pre_move_amount_r        <= '0;
            for (int k = 0; k < acb_pkg::NUM_CMP; k++) cmp_val_r[k] <= '0;
        end else if (reg_wr) begin
            if (reg_addr == acb_pkg::OFF_SETUP_A) comparator_setup_a_r <= reg_wdata;
            if (reg_addr == acb_pkg::OFF_SETUP_B) comparator_setup_b_r <= reg_wdata;
            if (reg_addr == acb_pkg::OFF_IRQ_EN) event_interrupt_enable_r <= reg_wdata;
            if (reg_addr == acb_pkg::OFF_PRE_MOVE) pre_move_amount_r <= reg_wdata[W-1:0];
            for (int k = 0; k < acb_pkg::NUM_CMP; k++) begin
                if (reg_addr == acb_pkg::OFF_CMP_BASE + 8'(4 * k))
                    cmp_val_r[k] <= reg_wdata[W-1:0];
            end
        end
    end

    // Event causes: latched on a fresh enabled match, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cause_r   <= 5'h00;
            match_d_r <= 5'h00;
        end else begin
            match_d_r <= match;
            if (reg_wr && reg_addr == acb_pkg::OFF_CAUSE)
                cause_r <= (cause_r & ~reg_wdata[acb_pkg::EVT_LSB +: 5]) | fire_en;
            else
                cause_r <= cause_r | fire_en;
        end
    end

    // Interrupt, status and actions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_n              <= 1'b1;
            cmp_match          <= 5'h00;
            stop_now           <= 1'b0;
            stop_decel         <= 1'b0;
            preload_load       <= 1'b0;
            active_move_amount <= '0;
            index_sync_pulse   <= 1'b0;
            plus_soft_limit    <= 1'b0;
            minus_soft_limit   <= 1'b0;
        end else begin
            irq_n <= ~|(cause_r & event_interrupt_enable_r[acb_pkg::EVT_LSB +: 5]);
            cmp_match    <= match;
            stop_now     <= any_stop;
            stop_decel   <= any_decel;
            preload_load <= any_load;
            if (any_load) active_move_amount <= pre_move_amount_r;
            index_sync_pulse <= index_hit[3];
            plus_soft_limit  <= match[0] && mth[0] == acb_pkg::M_SL;
            minus_soft_limit <= match[1] && mth[1] == acb_pkg::M_SL;
        end
    end

    // Ring counters, valid only with plain equality
    assign ring1_en = comparator_setup_a_r[acb_pkg::RING1_BIT] && mth[0] == acb_pkg::M_EQ;
    assign ring2_en = comparator_setup_a_r[acb_pkg::RING2_BIT] && mth[1] == acb_pkg::M_EQ;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_ring_load   <= 1'b0;
            cmd_ring_value  <= '0;
            mech_ring_load  <= 1'b0;
            mech_ring_value <= '0;
        end else begin
            cmd_ring_load  <= 1'b0;
            mech_ring_load <= 1'b0;
            if (ring1_en && cnt_step[0]) begin
                if (cnt_up[0] && command_position_counter == W'(cmp_val_r[0] + 1'b1)) begin
                    cmd_ring_load  <= 1'b1;
                    cmd_ring_value <= '0;
                end else if (!cnt_up[0] && command_position_counter == '1) begin
                    cmd_ring_load  <= 1'b1;
                    cmd_ring_value <= cmp_val_r[0];
                end
            end
            if (ring2_en && cnt_step[1]) begin
                if (cnt_up[1] && mechanical_position_counter == W'(cmp_val_r[1] + 1'b1)) begin
                    mech_ring_load  <= 1'b1;
                    mech_ring_value <= '0;
                end else if (!cnt_up[1] && mechanical_position_counter == '1) begin
                    mech_ring_load  <= 1'b1;
                    mech_ring_value <= cmp_val_r[1];
                end
            end
        end
    end

    // Register reads, data valid only the cycle after the strobe
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_addr)
            acb_pkg::OFF_SETUP_A:  rdata_nxt = comparator_setup_a_r;
            acb_pkg::OFF_SETUP_B:  rdata_nxt = comparator_setup_b_r;
            acb_pkg::OFF_IRQ_EN:   rdata_nxt = event_interrupt_enable_r;
            acb_pkg::OFF_CAUSE:    rdata_nxt[acb_pkg::EVT_LSB +: 5] = cause_r;
            acb_pkg::OFF_STATUS:   rdata_nxt[acb_pkg::EVT_LSB +: 5] = match;
            acb_pkg::OFF_PRE_MOVE: rdata_nxt[W-1:0] = pre_move_amount_r;
            acb_pkg::OFF_ACT_MOVE: rdata_nxt[W-1:0] = active_move_amount;
            default: begin
                for (int k = 0; k < acb_pkg::NUM_CMP; k++) begin
                    if (reg_addr == acb_pkg::OFF_CMP_BASE + 8'(4 * k))
                        rdata_nxt[W-1:0] = cmp_val_r[k];
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) reg_rdata <= 32'h0000_0000;
        else reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end

    irq_drive_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        |(cause_r & event_interrupt_enable_r[12:8]) |=> !irq_n)
        else $error("Enabled cause did not pull the interrupt low");

    cause_latch_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        |fire_en |=> ((cause_r & $past(fire_en)) == $past(fire_en)))
        else $error("Fresh enabled match did not set its cause bit");

    status_read_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == acb_pkg::OFF_STATUS |=> reg_rdata[12:8] == $past(match))
        else $error("Status read does not show live matches");

    stop_act_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rise[0] && act[0] == 2'b01 |=> stop_now)
        else $error("Immediate stop action missing");

    move_copy_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        preload_load |-> active_move_amount == $past(pre_move_amount_r))
        else $error("Pre move amount not copied on load");

    ring_gate_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        cmd_ring_load |-> $past(ring1_en) && $past(cnt_step[0]))
        else $error("Command ring load without ring mode");

    defl_abs_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        defl_abs <= W'(acb_pkg::DEFL_MAX))
        else $error("Deflection magnitude out of range");

    idx_pulse_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        index_hit[3] |=> index_sync_pulse)
        else $error("Index hit gave no index pulse");

    minus_limit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        match[1] && mth[1] == acb_pkg::M_SL |=> minus_soft_limit)
        else $error("Negative soft limit not raised");

    cause_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == acb_pkg::OFF_CAUSE && reg_wdata[8] && !fire_en[0] |=> !cause_r[0])
        else $error("Cause bit not cleared by write");

    decel_act_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rise[0] && act[0] == 2'b10 |=> stop_decel)
        else $error("Deceleration stop action missing");

    mech_ring_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mech_ring_load |-> $past(ring2_en) && $past(cnt_step[1]))
        else $error("Mechanical ring load without ring mode");
endmodule : acb_bank

// ### bench/tb_top.sv
/*
 * Self-checking bench for the comparator bank: register port, methods,
 * actions, causes, index pulse, soft limits and ring loads.
 * Assumes acb_bank and acb_pkg compiled first; one 40 MHz clock.
 */
`timescale 1ns/100ps
module tb_top;
    logic               clk;
    logic               rst_n;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    logic signed [27:0] cmd_c;
    logic signed [27:0] mech_c;
    logic signed [15:0] defl;
    logic signed [27:0] gp_c;
    logic signed [27:0] pos_c;
    logic [27:0]        speed;
    logic [3:0]         cnt_step;
    logic [3:0]         cnt_up;
    logic               irq_n;
    logic [4:0]         cmp_match;
    logic               stop_now;
    logic               stop_decel;
    logic               preload_load;
    logic [27:0]        act_mv;
    logic               idx_p;
    logic               plus_sl;
    logic               minus_sl;
    logic               cring;
    logic [27:0]        cring_v;
    logic               mring;
    logic [27:0]        mring_v;
    logic               rd_seen;
    logic [31:0]        expq[$];
    logic [31:0]        lf;
    logic [27:0]        c;
    int                 n_mismatch;
    int                 tests_run;
    int                 n_stop;
    int                 n_decel;
    int                 n_load;
    int                 n_idx;
    int                 n_ring;
    int                 cycles;

    localparam logic [2:0] MT [10] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
    localparam int         OFS[10] = '{0, 0, 0, 0, 0, 0, -1, 0, 1, 0};
    localparam bit         UPD[10] = '{1, 0, 1, 0, 0, 1, 1, 1, 1, 1};
    localparam bit         EXP[10] = '{1, 1, 1, 0, 1, 0, 1, 0, 1, 0};

    acb_bank u_acb_bank (
        .clk                         (clk),
        .rst_n                       (rst_n),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_rdata                   (reg_rdata),
        .command_position_counter    (cmd_c),
        .mechanical_position_counter (mech_c),
        .deflection_counter          (defl),
        .general_purpose_counter     (gp_c),
        .positioning_counter         (pos_c),
        .current_speed               (speed),
        .cnt_step                    (cnt_step),
        .cnt_up                      (cnt_up),
        .irq_n                       (irq_n),
        .cmp_match                   (cmp_match),
        .stop_now                    (stop_now),
        .stop_decel                  (stop_decel),
        .preload_load                (preload_load),
        .active_move_amount          (act_mv),
        .index_sync_pulse            (idx_p),
        .plus_soft_limit             (plus_sl),
        .minus_soft_limit            (minus_sl),
        .cmd_ring_load               (cring),
        .cmd_ring_value              (cring_v),
        .mech_ring_load              (mring),
        .mech_ring_value             (mring_v)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask : rd

    task automatic drive(input logic [27:0] v, input logic up);
        @(posedge clk);
        cmd_c <= v;
        mech_c <= v;
        gp_c <= v;
        pos_c <= v + 28'h2;
        speed <= v + 28'h1;
        defl <= v[15:0];
        cnt_step <= 4'hf;
        cnt_up <= {4{up}};
        @(posedge clk);
        cnt_step <= 4'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask : drive

    task automatic cfg(input int n, input logic [3:0] m, input logic [1:0] a,
                       input logic [2:0] s, input logic [27:0] v);
        logic [31:0] wa;
        wa = (n == 3) ? {a, m, s[1:0], 24'h0} :
             ((n < 3) ? ({25'h0, a, m[2:0], s[1:0]} << (8 * n)) : 32'h0);
        wr(8'h00, wa);
        wr(8'h04, (n == 4) ? {24'h0, a, m[2:0], s} : 32'h0);
        wr(8'h14 + 8'(4 * n), {4'h0, v});
    endtask : cfg

    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) if (rd_seen) begin
        chk("reg_rdata", reg_rdata, expq.pop_front());
    end

    always @(posedge clk) begin
        n_stop <= n_stop + int'(stop_now);
        n_decel <= n_decel + int'(stop_decel);
        n_load <= n_load + int'(preload_load);
        n_idx <= n_idx + int'(idx_p);
        n_ring <= n_ring + int'(cring) + int'(mring);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, cnt_step, cnt_up} = '0;
        {cmd_c, mech_c, defl, gp_c, pos_c, speed} = '0;
        {n_mismatch, tests_run, n_stop, n_decel, n_load, n_idx, n_ring, cycles} = '0;
        lf = 32'h4c3b;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk("irq_n", irq_n, 1'b1);
        for (int a = 0; a <= 8'h30; a += 4) rd(8'(a), 32'h0);
        wr(8'h10, 32'hffff_ffff);
        wr(8'h2c, 32'hffff_ffff);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h10, 32'h0);
        rd(8'h2c, 32'h0);
        rd(8'h30, 32'h0);
        for (int n = 0; n < 5; n++) begin
            for (int i = 0; i < 10; i++) begin
                lf = lfsr(lf);
                c = {2'b00, lf[25:1], 1'b1};
                cfg(n, {1'b0, MT[i]}, 2'b00, 3'h0, c);
                drive(c + 28'(OFS[i]), UPD[i]);
                chk("cmp_match", cmp_match, 5'(EXP[i]) << n);
                rd(acb_pkg::OFF_STATUS, {19'h0, 5'(EXP[i]) << n, 8'h0});
            end
        end
        lf = lfsr(lf);
        wr(acb_pkg::OFF_PRE_MOVE, {4'h0, lf[27:0]});
        for (int a = 0; a < 4; a++) begin
            cfg(0, 4'h1, 2'(a), 3'h0, c);
            drive(c - 28'h1, 1'b1);
            {n_stop, n_decel, n_load} = '0;
            drive(c, 1'b1);
            drive(c, 1'b1);
            chk("stop_now", n_stop, a == 1);
            chk("stop_decel", n_decel, a == 2);
            chk("preload", n_load, a == 3);
        end
        rd(acb_pkg::OFF_ACT_MOVE, {4'h0, lf[27:0]});
        chk("active_move", act_mv, {4'h0, lf[27:0]});
        cfg(0, 4'h1, 2'b00, 3'h0, c);
        drive(c, 1'b1);
        chk("irq_n", irq_n, 1'b1);
        rd(8'h0c, 32'h0);
        drive(c - 28'h1, 1'b1);
        wr(8'h08, 32'h1f00);
        drive(c, 1'b1);
        chk("irq_n", irq_n, 1'b0);
        rd(8'h0c, 32'h100);
        drive(c - 28'h1, 1'b1);
        rd(8'h0c, 32'h100);
        rd(8'h10, 32'h0);
        wr(8'h0c, 32'h1f00);
        rd(8'h0c, 32'h0);
        chk("irq_n", irq_n, 1'b1);
        wr(8'h08, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cfg(3, (i == 0) ? 4'h8 : ((i < 3) ? 4'h9 : 4'ha), 2'b00, 3'h3, c);
            drive(28'h0, 1'b1);
            n_idx = 0;
            drive(c, (i == 0 || i == 1 || i == 4));
            chk("index_pulse", n_idx, (i != 2 && i != 4));
        end
        cfg(0, 4'h6, 2'b00, 3'h0, c);
        drive(c + 28'h1, 1'b1);
        chk("plus_limit", plus_sl, 1'b1);
        drive(c, 1'b1);
        chk("plus_limit", plus_sl, 1'b0);
        cfg(1, 4'h6, 2'b00, 3'h0, c);
        drive(c - 28'h1, 1'b0);
        chk("minus_limit", minus_sl, 1'b1);
        cfg(0, 4'h1, 2'b00, 3'h2, 28'h5);
        drive(28'hffffffb, 1'b1);
        chk("cmp_match", cmp_match, 5'h01);
        cfg(0, 4'h1, 2'b00, 3'h2, 28'h7fff);
        drive(28'h0008000, 1'b1);
        chk("cmp_match", cmp_match, 5'h01);
        for (int s = 0; s < 3; s++) begin
            cfg(4, 4'h1, 2'b00, (s == 0) ? 3'h5 : ((s == 1) ? 3'h4 : 3'h0), c + 28'(s + 1));
            drive(c, 1'b1);
            chk("cmp_match", cmp_match, (s < 2) ? 5'h10 : 5'h00);
        end
        for (int n = 0; n < 2; n++) begin
            wr(8'h00, ({25'h0, 2'b00, 3'b001, 2'(n)} << (8 * n)) | (32'h80 << (8 * n)));
            wr(8'h14 + 8'(4 * n), {4'h0, c});
            rd(8'h00, ({25'h0, 2'b00, 3'b001, 2'(n)} << (8 * n)) | (32'h80 << (8 * n)));
            drive(c - 28'h1, 1'b1);
            n_ring = 0;
            drive(c + 28'h1, 1'b1);
            chk("ring_value", (n == 0) ? cring_v : mring_v, 28'h0);
            drive(28'hfffffff, 1'b0);
            chk("ring_value", (n == 0) ? cring_v : mring_v, c);
            chk("ring_loads", n_ring, 2);
        end
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : tb_top
